// ===== logic/rtc_core.sv
// real-time counter core: prescaler, three-mode counter, registers on AXI4-Lite
// Operation
// - 10-bit prescaler output drives a 32-bit counter whose meaning follows the mode.
// - modes: 32-bit counter, 16-bit counter, clock/calendar with alarm.
// - mode, prescaler, clear-on-match, hour format and event control writable only disabled.
// - protected writes while running or being enabled are dropped.
// - protected writes during a disable are held until the disable completes.
// - count rate is source rate divided by two to the prescaler field; field values above 10 divide by 2^10.
// - only power-on reset or soft reset clears the block.
// - counter runs in sleep while its source runs; flags may wake the system.
// - routed events can trigger actions without waking the processor.
// - source-clock registers pass a synchronisation step.
// - debugger halt stops the counter unless debug control says keep running.
// - write lock blocks writes except flags, read request, status, debug control.
// - debugger writes bypass the write lock.
// - periodic prescaler events plus overflow and match flags and events.
// - clear-on-match restarts the counter from zero on a compare 0 match in wide and calendar modes.
// - one 32-bit compare in wide mode, two 16-bit compares in half mode.
// - calendar keeps seconds to year, 12 or 24 hour, with leap years.
// - mode field 00 wide, 01 half, 10 calendar.
// - soft reset restores all but debug control, bus handshake state and the source synchroniser, and leaves counter disabled.
// - wide mode increments per tick, wraps all ones to zero, sets overflow.
`timescale 1ns/1ns
`include "rtc_regs.svh"
module rtc_core
  import rtc_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        aclken,
  input  wire logic        counter_source_clock,
  input  wire logic        debug_halt,
  input  wire logic        debugger_access,
  input  wire logic        write_lock,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             wake_request,
  output logic [7:0]       evt_period,
  output logic             evt_match0,
  output logic             evt_match1,
  output logic             evt_overflow
);

  function automatic rtc_reg_type reg_decode(input logic [7:0] a);
    unique case (a)
      `RTC_OFF_CTRL:    reg_decode = RTC_R_CTRL;
      `RTC_OFF_READ_REQUEST_REG: reg_decode = RTC_R_READ_REQUEST_REG;
      `RTC_OFF_EVENT_CONTROL_REG:  reg_decode = RTC_R_EVENT_CONTROL_REG;
      `RTC_OFF_IRQFLAG: reg_decode = RTC_R_IRQFLAG;
      `RTC_OFF_STATUS:  reg_decode = RTC_R_STATUS;
      `RTC_OFF_DEBUG_CONTROL_REG: reg_decode = RTC_R_DEBUG_CONTROL_REG;
      `RTC_OFF_COUNT:   reg_decode = RTC_R_COUNT;
      `RTC_OFF_PERIOD:  reg_decode = RTC_R_PERIOD;
      `RTC_OFF_COMP0:   reg_decode = RTC_R_COMP0;
      `RTC_OFF_COMP1:   reg_decode = RTC_R_COMP1;
      default:          reg_decode = RTC_R_NONE;
    endcase
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] s);
    logic [31:0] m;
    m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    merge = (old & ~m) | (nw & m);
  endfunction

  function automatic logic [4:0] days_in(input logic [3:0] mon, input logic leap);
    unique case (mon)
      4'h2:                   days_in = leap ? 5'h1D : 5'h1C;
      4'h4, 4'h6, 4'h9, 4'hB: days_in = 5'h1E;
      default:                days_in = 5'h1F;
    endcase
  endfunction

  // one-second step of the calendar word; msb flags the year-63 wrap
  function automatic logic [32:0] cal_step(input logic [31:0] v, input logic h12);
    logic [5:0] sec;
    logic [5:0] mnt;
    logic [4:0] hr;
    logic [4:0] day;
    logic [3:0] mon;
    logic [5:0] yr;
    logic       roll;
    logic       wrap;
    sec = v[5:0];
    mnt = v[11:6];
    hr = v[16:12];
    day = v[21:17];
    mon = v[25:22];
    yr = v[31:26];
    roll = 1'b0;
    wrap = 1'b0;
    if (sec != 6'h3B) begin
      sec = 6'(sec + 6'h1);
    end else begin
      sec = 6'h0;
      if (mnt != 6'h3B) begin
        mnt = 6'(mnt + 6'h1);
      end else begin
        mnt = 6'h0;
        if (h12) begin
          // bit 4 is the afternoon flag; 11 pm to 12 am ends the day
          if (hr[3:0] == 4'hB) begin
            roll = hr[4];
            hr = {~hr[4], 4'hC};
          end else if (hr[3:0] == 4'hC) begin
            hr = {hr[4], 4'h1};
          end else begin
            hr = 5'(hr + 5'h1);
          end
        end else if (hr == 5'h17) begin
          hr = 5'h0;
          roll = 1'b1;
        end else begin
          hr = 5'(hr + 5'h1);
        end
      end
    end
    if (roll) begin
      if (day != days_in(mon, yr[1:0] == 2'h0)) begin
        day = 5'(day + 5'h1);
      end else begin
        day = 5'h1;
        if (mon != 4'hC) begin
          mon = 4'(mon + 4'h1);
        end else begin
          mon = 4'h1;
          wrap = (yr == 6'h3F);
          yr = 6'(yr + 6'h1);
        end
      end
    end
    cal_step = {wrap, yr, mon, day, hr, mnt, sec};
  endfunction

  logic        src_meta;
  logic        src_sync;
  logic        src_prev;
  logic [9:0]  presc;
  logic        ctrl_enable;
  logic [1:0]  ctrl_mode;
  logic        ctrl_hfmt;
  logic        ctrl_clr;
  logic [3:0]  ctrl_psel;
  logic [15:0] event_control_reg;
  logic [7:0]  flags;
  logic        dbg_run;
  logic [31:0] count;
  logic [31:0] count_snap;
  logic [15:0] period;
  logic [31:0] comp0;
  logic [15:0] comp1;
  logic [1:0]  sync_cnt;
  rtc_sync_type pend_kind;
  logic [31:0] pend_data;
  logic        aw_hold;
  logic        w_hold;
  logic [7:0]  aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic [31:0] next_count;
  logic        set_ovf;
  logic        set_m0;
  logic        set_m1;

  wire        busy = (sync_cnt != 2'h0);
  wire        sync_done = (sync_cnt == 2'h1);
  wire        ctrl_pend = busy && (pend_kind == RTC_SYNC_CTRL);
  wire        soft_apply = sync_done && ctrl_pend && pend_data[`RTC_CTRL_SOFT_RESET_BIT];
  wire        clr_all = !aresetn || soft_apply;
  wire        src_edge = src_sync && !src_prev;
  wire        run = ctrl_enable && !(debug_halt && !dbg_run);
  wire [3:0]  psel_eff = (ctrl_psel > `RTC_PSC_MAX) ? `RTC_PSC_MAX : ctrl_psel;
  wire [9:0]  psc_mask = 10'((11'h1 << psel_eff) - 11'h1);
  wire        tick = src_edge && run && ((presc & psc_mask) == psc_mask);
  wire [31:0] ctrl_word = {20'h0, ctrl_psel, ctrl_clr, ctrl_hfmt, 2'b00, ctrl_mode,
                           ctrl_enable, 1'b0};
  wire [7:0]  per_raw;

  // periodic events: prescaler bit n completes a cycle
  genvar n;
  generate
    for (n = 0; n < 8; n++) begin : g_per
      assign per_raw[n] = src_edge && run && (&presc[n:0]);
    end
  endgenerate

  // write side of the bus
  wire         wr_fire = aw_hold && w_hold && !s_axi_bvalid && !busy;
  wire rtc_reg_type wr_reg = reg_decode(aw_addr_q);
  wire         lock_exempt = (wr_reg == RTC_R_IRQFLAG) || (wr_reg == RTC_R_READ_REQUEST_REG) ||
                             (wr_reg == RTC_R_STATUS) || (wr_reg == RTC_R_DEBUG_CONTROL_REG);
  wire         wr_locked = write_lock && !debugger_access && !lock_exempt;
  wire         wr_bad = (wr_reg == RTC_R_NONE) || wr_locked;
  wire         wr_ok = wr_fire && !wr_bad;
  wire [31:0]  ctrl_new = merge(ctrl_word, w_data_q, w_strb_q);
  wire [31:0]  ctrl_keep = ctrl_enable ?
               ((ctrl_new & ~`RTC_CTRL_PROT) | (ctrl_word & `RTC_CTRL_PROT)) : ctrl_new;
  wire         wr_sync = wr_ok && ((wr_reg == RTC_R_CTRL) || (wr_reg == RTC_R_COUNT) ||
                                   (wr_reg == RTC_R_READ_REQUEST_REG));
  wire [7:0]   flag_clr = (wr_ok && wr_reg == RTC_R_IRQFLAG) ?
                          (w_data_q[7:0] & {8{w_strb_q[0]}}) : 8'h00;
  wire         evc_wr = wr_ok && (wr_reg == RTC_R_EVENT_CONTROL_REG) && !ctrl_enable;

  assign s_axi_awready = !aw_hold && !busy;
  assign s_axi_wready  = !w_hold && !busy;
  assign s_axi_arready = !s_axi_rvalid;

  // read side of the bus
  wire rtc_reg_type rd_reg = reg_decode(s_axi_araddr);
  wire [31:0]  rd_word =
    (rd_reg == RTC_R_CTRL)    ? (ctrl_pend ? pend_data : ctrl_word) :
    (rd_reg == RTC_R_EVENT_CONTROL_REG)  ? {16'h0, event_control_reg} :
    (rd_reg == RTC_R_IRQFLAG) ? {24'h0, flags} :
    (rd_reg == RTC_R_STATUS)  ? {24'h0, busy, 7'h0} :
    (rd_reg == RTC_R_DEBUG_CONTROL_REG) ? {31'h0, dbg_run} :
    (rd_reg == RTC_R_COUNT)   ? count_snap :
    (rd_reg == RTC_R_PERIOD)  ? {16'h0, period} :
    (rd_reg == RTC_R_COMP0)   ? comp0 :
    (rd_reg == RTC_R_COMP1)   ? {16'h0, comp1} : 32'h0000_0000;

  // counter step per mode
  always_comb begin
    next_count = count;
    set_ovf = 1'b0;
    set_m0 = 1'b0;
    set_m1 = 1'b0;
    if (tick) begin
      unique case (ctrl_mode)
        RTC_WIDE: begin
          set_m0 = (count == comp0);
          if (set_m0 && ctrl_clr) begin
            next_count = 32'h0000_0000;
            set_ovf = 1'b1;
          end else begin
            next_count = 32'(count + 32'h1);
            set_ovf = &count;
          end
        end
        RTC_HALF: begin
          set_m0 = (count[15:0] == comp0[15:0]);
          set_m1 = (count[15:0] == comp1);
          if (count[15:0] == period) begin
            next_count = 32'h0000_0000;
            set_ovf = 1'b1;
          end else begin
            next_count = {16'h0, 16'(count[15:0] + 16'h1)};
          end
        end
        RTC_CAL: begin
          set_m0 = (count == comp0);
          if (set_m0 && ctrl_clr) begin
            next_count = 32'h0000_0000;
            set_ovf = 1'b1;
          end else begin
            {set_ovf, next_count} = cal_step(count, ctrl_hfmt);
          end
        end
        default: ;
      endcase
    end
  end

  // source clock is another domain: two flops before use
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      src_meta <= 1'b0;
      src_sync <= 1'b0;
      src_prev <= 1'b0;
    end else if (aclken) begin
      src_meta <= counter_source_clock;
      src_sync <= src_meta;
      src_prev <= src_sync;
    end
  end

  // bus handshake state, untouched by soft reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= `RTC_RST_WORD;
      w_strb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= `RTC_RST_WORD;
      s_axi_rresp <= 2'b00;
    end else if (aclken) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_hold <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_hold <= 1'b0;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_bad ? 2'b10 : 2'b00;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= (rd_reg == RTC_R_NONE) ? 2'b10 : 2'b00;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // debug control survives soft reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dbg_run <= 1'b0;
    end else if (aclken && wr_ok && wr_reg == RTC_R_DEBUG_CONTROL_REG && w_strb_q[0]) begin
      dbg_run <= w_data_q[0];
    end
  end

  // synchronisation step for control, count and read request
  always_ff @(posedge aclk) begin
    if (clr_all) begin
      sync_cnt <= 2'h0;
      pend_kind <= RTC_SYNC_CTRL;
      pend_data <= `RTC_RST_WORD;
    end else if (aclken) begin
      if (wr_sync) begin
        sync_cnt <= `RTC_SYNC_CYCLES;
        pend_kind <= (wr_reg == RTC_R_CTRL) ? RTC_SYNC_CTRL :
                     (wr_reg == RTC_R_COUNT) ? RTC_SYNC_COUNT : RTC_SYNC_READ;
        pend_data <= (wr_reg == RTC_R_CTRL) ? ctrl_keep : merge(count, w_data_q, w_strb_q);
      end else if (busy) begin
        sync_cnt <= 2'(sync_cnt - 2'h1);
      end
    end
  end

  // configuration, cleared by power-on or soft reset
  always_ff @(posedge aclk) begin
    if (clr_all) begin
      ctrl_enable <= 1'b0;
      ctrl_mode <= RTC_WIDE;
      ctrl_hfmt <= 1'b0;
      ctrl_clr <= 1'b0;
      ctrl_psel <= 4'h0;
      event_control_reg <= 16'h0000;
      period <= `RTC_RST_PERIOD;
      comp0 <= `RTC_RST_WORD;
      comp1 <= 16'h0000;
    end else if (aclken) begin
      if (sync_done && pend_kind == RTC_SYNC_CTRL) begin
        ctrl_enable <= pend_data[`RTC_CTRL_EN];
        ctrl_mode <= pend_data[`RTC_CTRL_MODE_LO +: 2];
        ctrl_hfmt <= pend_data[`RTC_CTRL_HFMT];
        ctrl_clr <= pend_data[`RTC_CTRL_CLR];
        ctrl_psel <= pend_data[`RTC_CTRL_PSC_LO +: 4];
      end
      if (evc_wr) begin
        event_control_reg <= 16'(merge({16'h0, event_control_reg}, w_data_q, w_strb_q));
      end
      if (wr_ok && wr_reg == RTC_R_PERIOD) begin
        period <= 16'(merge({16'h0, period}, w_data_q, w_strb_q));
      end
      if (wr_ok && wr_reg == RTC_R_COMP0) begin
        comp0 <= merge(comp0, w_data_q, w_strb_q);
      end
      if (wr_ok && wr_reg == RTC_R_COMP1) begin
        comp1 <= 16'(merge({16'h0, comp1}, w_data_q, w_strb_q));
      end
    end
  end

  // counting state; runs in any sleep state, only the source clock matters
  always_ff @(posedge aclk) begin
    if (clr_all) begin
      presc <= 10'h000;
      count <= `RTC_RST_WORD;
      count_snap <= `RTC_RST_WORD;
      flags <= 8'h00;
      evt_period <= 8'h00;
      evt_match0 <= 1'b0;
      evt_match1 <= 1'b0;
      evt_overflow <= 1'b0;
    end else if (aclken) begin
      if (src_edge && run) begin
        presc <= 10'(presc + 10'h1);
      end
      if (sync_done && pend_kind == RTC_SYNC_COUNT) begin
        count <= pend_data;
      end else if (tick) begin
        count <= next_count;
      end
      if (sync_done && pend_kind == RTC_SYNC_READ) begin
        count_snap <= count;
      end
      // a set in the clearing cycle wins
      flags <= (flags & ~flag_clr) |
               {set_ovf, 5'h00, set_m1, set_m0};
      evt_period <= per_raw & event_control_reg[7:0];
      evt_match0 <= set_m0 && event_control_reg[`RTC_EVC_M0];
      evt_match1 <= set_m1 && event_control_reg[`RTC_EVC_M1];
      evt_overflow <= set_ovf && event_control_reg[`RTC_EVC_OVF];
    end
  end

  assign wake_request = |flags;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_sync_start;
    aclken && wr_sync;
  endsequence
  sequence s_busy_hold;
    busy[*3];
  endsequence

  property p_sync_busy;
    s_sync_start |=> s_busy_hold;
  endproperty
  a_sync_busy: assert property (p_sync_busy) else $error("busy not held");

  property p_no_accept_busy;
    busy |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_no_accept_busy: assert property (p_no_accept_busy) else $error("write taken busy");

  property p_wrap32;
    aclken && tick && ctrl_mode == RTC_WIDE && count == 32'hFFFF_FFFF && comp0 != count
      && !(sync_done && pend_kind == RTC_SYNC_COUNT)
      |=> count == 32'h0000_0000 && flags[`RTC_FLAG_OVF];
  endproperty
  a_wrap32: assert property (p_wrap32) else $error("no wrap to zero");

  property p_evc_protect;
    aclken && wr_ok && wr_reg == RTC_R_EVENT_CONTROL_REG && ctrl_enable && !soft_apply |=> $stable(event_control_reg);
  endproperty
  a_evc_protect: assert property (p_evc_protect) else $error("protected write taken");

  property p_halt;
    aclken && ctrl_enable && debug_halt && !dbg_run && !busy |=> $stable(count) && $stable(presc);
  endproperty
  a_halt: assert property (p_halt) else $error("counter ran in halt");

  property p_soft_reset;
    aclken && soft_apply |=> !ctrl_enable && event_control_reg == 16'h0000 && count == 32'h0000_0000;
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("soft reset incomplete");

  property p_lock;
    aclken && wr_fire && wr_reg == RTC_R_COMP0 && write_lock && !debugger_access
      && !soft_apply |=> $stable(comp0) && s_axi_bresp == 2'b10;
  endproperty
  a_lock: assert property (p_lock) else $error("locked write taken");

  property p_match_clear;
    aclken && tick && (ctrl_mode == RTC_WIDE || ctrl_mode == RTC_CAL) && ctrl_clr
      && count == comp0
      && !(sync_done && pend_kind == RTC_SYNC_COUNT)
      |=> count == 32'h0000_0000 && flags[`RTC_FLAG_OVF] && flags[`RTC_FLAG_M0];
  endproperty
  a_match_clear: assert property (p_match_clear) else $error("match clear failed");

  property p_half_period;
    aclken && tick && ctrl_mode == RTC_HALF && count[15:0] == period
      && !(sync_done && pend_kind == RTC_SYNC_COUNT) |=> count[15:0] == 16'h0000;
  endproperty
  a_half_period: assert property (p_half_period) else $error("half wrap failed");

  property p_tick_rate;
    tick |-> src_edge && ((presc & psc_mask) == psc_mask);
  endproperty
  a_tick_rate: assert property (p_tick_rate) else $error("tick off divider");

endmodule // rtc_core

// ===== pkg/rtc_pkg.sv
// types shared by the real-time counter core
package rtc_pkg;
  typedef enum logic [1:0] {
    RTC_WIDE = 2'b00,
    RTC_HALF = 2'b01,
    RTC_CAL  = 2'b10
  } rtc_mode_type;
  typedef enum logic [1:0] {
    RTC_SYNC_CTRL  = 2'b00,
    RTC_SYNC_COUNT = 2'b01,
    RTC_SYNC_READ  = 2'b10
  } rtc_sync_type;
  typedef enum logic [3:0] {
    RTC_R_NONE    = 4'b0000,
    RTC_R_CTRL    = 4'b0001,
    RTC_R_READ_REQUEST_REG = 4'b0010,
    RTC_R_EVENT_CONTROL_REG  = 4'b0011,
    RTC_R_IRQFLAG = 4'b0100,
    RTC_R_STATUS  = 4'b0101,
    RTC_R_DEBUG_CONTROL_REG = 4'b0110,
    RTC_R_COUNT   = 4'b0111,
    RTC_R_PERIOD  = 4'b1000,
    RTC_R_COMP0   = 4'b1001,
    RTC_R_COMP1   = 4'b1010
  } rtc_reg_type;
endpackage

// ===== pkg/rtc_regs.svh
// register offsets, field positions, reset values and timing counts of the real-time counter
`ifndef RTC_REGS_SVH
`define RTC_REGS_SVH
`define RTC_OFF_CTRL      8'h00
`define RTC_OFF_READ_REQUEST_REG   8'h04
`define RTC_OFF_EVENT_CONTROL_REG    8'h08
`define RTC_OFF_IRQFLAG   8'h0C
`define RTC_OFF_STATUS    8'h10
`define RTC_OFF_DEBUG_CONTROL_REG   8'h14
`define RTC_OFF_COUNT     8'h18
`define RTC_OFF_PERIOD    8'h1C
`define RTC_OFF_COMP0     8'h20
`define RTC_OFF_COMP1     8'h24
`define RTC_CTRL_SOFT_RESET_BIT    0
`define RTC_CTRL_EN       1
`define RTC_CTRL_MODE_LO  2
`define RTC_CTRL_HFMT     6
`define RTC_CTRL_CLR      7
`define RTC_CTRL_PSC_LO   8
`define RTC_CTRL_PROT     32'h0000_0FCC
`define RTC_FLAG_M0       0
`define RTC_FLAG_M1       1
`define RTC_FLAG_OVF      7
`define RTC_STATUS_BUSY   7
`define RTC_EVC_M0        8
`define RTC_EVC_M1        9
`define RTC_EVC_OVF       15
`define RTC_RST_WORD      32'h0000_0000
`define RTC_RST_PERIOD    16'hFFFF
`define RTC_SYNC_CYCLES   2'h3
`define RTC_PSC_MAX       4'hA
`endif

// ===== verification/test_rtc_core.sv
// self-checking bench for the real-time counter core
`timescale 1ns/1ns
module test_rtc_core
  import rtc_pkg::*;
;
  logic        aclk = 1'h0, aresetn = 1'h0, aclken = 1'h1, counter_source_clock = 1'h0;
  logic        debug_halt = 1'h0, debugger_access = 1'h0, write_lock = 1'h0;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic        wake_request, evt_match0, evt_match1, evt_overflow;
  logic [7:0]  evt_period;
  int          n_errors = 0, checked = 0, n_ovf = 0, n_m0 = 0, n_m1 = 0, n_per = 0;

  rtc_core rtc_core_inst (.aclk, .aresetn, .aclken, .counter_source_clock, .debug_halt,
    .debugger_access, .write_lock, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
    .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
    .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .wake_request, .evt_period, .evt_match0,
    .evt_match1, .evt_overflow);

  initial begin
    forever #2 aclk = ~aclk;
  end

  always @(posedge aclk) begin
    if (evt_overflow === 1'h1) n_ovf <= n_ovf + 1;
    if (evt_match0 === 1'h1) n_m0 <= n_m0 + 1;
    if (evt_match1 === 1'h1) n_m1 <= n_m1 + 1;
    if (evt_period[0] === 1'h1) n_per <= n_per + 1;
  end

  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", s, e, g);
      n_errors++;
    end
  endtask

  // handshake sampled at the falling edge, where nothing moves until the next rise
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_hs, w_hs, done;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    done = 1'h0;
    while (!done) begin
      @(negedge aclk);
      aw_hs = s_axi_awvalid && s_axi_awready;
      w_hs = s_axi_wvalid && s_axi_wready;
      done = s_axi_bvalid === 1'h1;
      if (done) chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
      @(posedge aclk);
      if (aw_hs) s_axi_awvalid <= 1'h0;
      if (w_hs) s_axi_wvalid <= 1'h0;
      if (done) s_axi_bready <= 1'h0;
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [1:0] er, input logic [31:0] e);
    logic hs, done;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    done = 1'h0;
    while (!done) begin
      @(negedge aclk);
      hs = s_axi_arvalid && s_axi_arready;
      done = s_axi_rvalid === 1'h1;
      if (done) chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
      if (done) chk($sformatf("reg %h", a), e, s_axi_rdata);
      @(posedge aclk);
      if (hs) s_axi_arvalid <= 1'h0;
      if (done) s_axi_rready <= 1'h0;
    end
  endtask

  task automatic cnt(input logic [31:0] e);
    wr(8'h04, 32'h1, 2'h0);
    repeat (4) @(posedge aclk);
    rd(8'h18, 2'h0, e);
  endtask

  // each source level held 3 cycles, slower than half the bus clock
  task automatic src(input int n);
    repeat (n) begin
      counter_source_clock <= 1'h1;
      repeat (3) @(posedge aclk);
      counter_source_clock <= 1'h0;
      repeat (3) @(posedge aclk);
    end
    repeat (4) @(posedge aclk);
  endtask

  task automatic t_reset;
    rd(8'h00, 2'h0, 32'h0);
    rd(8'h1C, 2'h0, 32'h0000_FFFF);
    rd(8'h30, 2'h2, 32'h0);
    $display("test reset done");
  endtask

  task automatic t_psc_halt;
    wr(8'h00, 32'h0000_0200, 2'h0);
    wr(8'h00, 32'h0000_0202, 2'h0);
    src(8);
    cnt(32'h2);
    debug_halt <= 1'h1;
    src(4);
    cnt(32'h2);
    wr(8'h14, 32'h1, 2'h0);
    src(4);
    cnt(32'h3);
    debug_halt <= 1'h0;
    $display("test prescaler and halt done");
  endtask

  task automatic t_protect;
    wr(8'h00, 32'h0, 2'h0);
    wr(8'h08, 32'h0000_8000, 2'h0);
    rd(8'h08, 2'h0, 32'h0000_8000);
    wr(8'h00, 32'h0000_0002, 2'h0);
    wr(8'h00, 32'h0000_0F8E, 2'h0);
    rd(8'h00, 2'h0, 32'h0000_0002);
    wr(8'h08, 32'h0, 2'h0);
    rd(8'h08, 2'h0, 32'h0000_8000);
    $display("test enable protection done");
  endtask

  task automatic t_overflow;
    wr(8'h18, 32'hFFFF_FFFE, 2'h0);
    repeat (4) @(posedge aclk);
    src(2);
    // match0 stays set from the first tick of count 0 against compare 0
    rd(8'h0C, 2'h0, 32'h0000_0081);
    chk("wake", 32'h1, {31'h0, wake_request});
    chk("ovf events", 32'h1, n_ovf);
    cnt(32'h0);
    wr(8'h0C, 32'h0000_0081, 2'h0);
    rd(8'h0C, 2'h0, 32'h0);
    $display("test overflow done");
  endtask

  task automatic t_lock;
    write_lock <= 1'h1;
    wr(8'h20, 32'h5, 2'h2);
    rd(8'h20, 2'h0, 32'h0);
    wr(8'h0C, 32'h0000_0080, 2'h0);
    debugger_access <= 1'h1;
    wr(8'h20, 32'h5, 2'h0);
    rd(8'h20, 2'h0, 32'h5);
    debugger_access <= 1'h0;
    write_lock <= 1'h0;
    $display("test write lock done");
  endtask

  task automatic t_soft_reset_bit;
    wr(8'h00, 32'h0, 2'h0);
    wr(8'h00, 32'h1, 2'h0);
    repeat (6) @(posedge aclk);
    rd(8'h00, 2'h0, 32'h0);
    rd(8'h08, 2'h0, 32'h0);
    rd(8'h20, 2'h0, 32'h0);
    rd(8'h1C, 2'h0, 32'h0000_FFFF);
    rd(8'h14, 2'h0, 32'h1);
    $display("test soft reset done");
  endtask

  // one source edge stands for one second at prescaler 0
  task automatic t_calendar;
    wr(8'h00, 32'h0000_0008, 2'h0);
    wr(8'h00, 32'h0000_0008, 2'h0);
    wr(8'h00, 32'h0000_0088, 2'h0);
    wr(8'h18, 32'h0F3F_7EFB, 2'h0);
    wr(8'h20, 32'h1042_0000, 2'h0);
    wr(8'h00, 32'h0000_008A, 2'h0);
    src(1);
    cnt(32'h1042_0000);
    src(1);
    cnt(32'h0);
    rd(8'h0C, 2'h0, 32'h0000_0081);
    $display("test calendar done");
  endtask

  task automatic t_half;
    wr(8'h00, 32'h0000_0004, 2'h0);
    wr(8'h00, 32'h0000_0004, 2'h0);
    wr(8'h1C, 32'h0000_0002, 2'h0);
    wr(8'h24, 32'h0000_0001, 2'h0);
    wr(8'h20, 32'h0, 2'h0);
    wr(8'h08, 32'h0000_0301, 2'h0);
    wr(8'h0C, 32'h0000_00FF, 2'h0);
    wr(8'h00, 32'h0000_0006, 2'h0);
    src(3);
    rd(8'h0C, 2'h0, 32'h0000_0083);
    cnt(32'h0);
    chk("match0 events", 32'h1, n_m0);
    chk("match1 events", 32'h1, n_m1);
    chk("period events", 32'h1, n_per);
    $display("test half counter done");
  endtask

  task automatic test_done;
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    t_reset;
    t_psc_halt;
    t_protect;
    t_overflow;
    t_lock;
    t_soft_reset_bit;
    t_calendar;
    t_half;
    test_done;
  end

  // whole sequence needs well under 2000 cycles
  initial begin
    repeat (20000) @(posedge aclk);
    n_errors++;
    test_done;
  end
endmodule // test_rtc_core
